// ---- rtl/fcp_defines.vh ----
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH
// Register byte offsets; channel registers as word index within the channel
`define FCP_OFS_MODE      12'h000
`define FCP_OFS_ENA       12'h004
`define FCP_OFS_DIS       12'h008
`define FCP_OFS_SR        12'h00C
`define FCP_OFS_IER       12'h010
`define FCP_OFS_IDR       12'h014
`define FCP_OFS_IMR       12'h018
`define FCP_OFS_ISR       12'h01C
`define FCP_OFS_CH_BASE   12'h200
`define FCP_CH_STRIDE_LSB 5
`define FCP_OFS_CMR       3'h0
`define FCP_OFS_CHANNEL_DUTY_VALUE      3'h1
`define FCP_OFS_CHANNEL_PERIOD_VALUE      3'h2
`define FCP_OFS_CCNT      3'h3
`define FCP_OFS_CUPD      3'h4
// Mode register fields
`define FCP_MR_DIVIDER_A_FACTOR_LSB   0
`define FCP_MR_DIVIDER_A_SOURCE_SEL_LSB   8
`define FCP_MR_DIVIDER_B_FACTOR_LSB   16
`define FCP_MR_DIVIDER_B_SOURCE_SEL_LSB   24
// Channel mode register fields
`define FCP_CMR_CSEL_LSB  0
`define FCP_CMR_CALG_BIT  8
`define FCP_CMR_CPOL_BIT  9
`define FCP_CMR_CPD_BIT   10
// Clock select codes
`define FCP_SEL_AUX_A     4'hB
`define FCP_SEL_AUX_B     4'hC
`define FCP_RST_ZERO      32'h0000_0000
`endif

// ---- rtl/fcp_chan.v ----
`timescale 1ns/100ps
`include "fcp_defines.vh"
// One waveform channel: counter, comparator, double buffer
module fcp_chan #(
  parameter CW = 16
) (
  input  wire          i_clk,
  input  wire          i_rst_b,
  input  wire          i_tick,      // Selected clock enable pulse
  input  wire          i_en,        // Channel running
  input  wire          i_start,     // Channel enable write
  input  wire          i_calg,      // Center aligned
  input  wire          i_cpol,      // Start level
  input  wire          i_cpd,       // Update target: 1 period, 0 duty
  input  wire          i_wr_prd,    // Direct period write
  input  wire          i_wr_dty,    // Direct duty write
  input  wire          i_wr_upd,    // Update register write
  input  wire [CW-1:0] i_wdata,     // Write data
  output reg  [CW-1:0] o_prd,       // Active period
  output reg  [CW-1:0] o_dty,       // Active duty
  output reg  [CW-1:0] o_cnt,       // Internal counter
  output reg           o_wave,      // channel_wave_out
  output wire          o_eop        // End of period pulse
);
  //----------------------------------------
  // State
  //----------------------------------------
  reg [CW-1:0] upd_r;    // Held update value
  reg          upd_pend_r; // Update waiting
  reg          down_r;   // Counting down
  wire at_top  = (o_cnt >= o_prd);
  wire at_zero = (o_cnt == {CW{1'b0}});
  // Left period spans exactly prd ticks
  wire at_end  = (o_cnt >= (o_prd - {{(CW-1){1'b0}},1'b1}));
  // [R18] center ends at zero going down
  // [R19] left ends at period
  assign o_eop = i_en & i_tick &
                 (i_calg ? (down_r & (at_zero | (o_cnt == {{(CW-1){1'b0}},1'b1})))
                         : at_end);
  //----------------------------------------
  // Counter and buffers
  //----------------------------------------
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cnt      <= {CW{1'b0}};
      o_prd      <= {CW{1'b0}};
      o_dty      <= {CW{1'b0}};
      upd_r      <= {CW{1'b0}};
      upd_pend_r <= 1'b0;
      down_r     <= 1'b0;
    end else begin
      // Direct writes while stopped
      if (i_wr_prd && !i_en) o_prd <= i_wdata;
      if (i_wr_dty && !i_en) o_dty <= i_wdata;
      // [R20] hold update until period end
      if (i_wr_upd) begin
        upd_r      <= i_wdata;
        upd_pend_r <= 1'b1;
      end
      if (i_start) begin
        // [R13] all started channels reset together
        o_cnt  <= {CW{1'b0}};
        down_r <= 1'b0;
      end else if (i_en && i_tick) begin
        // [R9] 16-bit up/down counter
        if (o_eop) begin
          o_cnt  <= {CW{1'b0}};
          down_r <= 1'b0;
          // [R12] apply buffered value at boundary
          if (upd_pend_r && !i_wr_upd) begin
            upd_pend_r <= 1'b0;
            if (i_cpd) o_prd <= upd_r;
            else       o_dty <= upd_r;
          end
        end else if (i_calg && (down_r || at_top)) begin
          down_r <= 1'b1;
          o_cnt  <= o_cnt - {{(CW-1){1'b0}},1'b1};
        end else begin
          o_cnt  <= o_cnt + {{(CW-1){1'b0}},1'b1};
        end
      end
    end
  end
  //----------------------------------------
  // Comparator output
  //----------------------------------------
  // [R10] first part of period at cpol
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wave <= 1'b0;
    end else if (!i_en) begin
      o_wave <= i_cpol;
    end else begin
      o_wave <= (o_cnt < (o_prd - o_dty)) ? i_cpol : ~i_cpol;
    end
  end
endmodule

// ---- rtl/fcp_top.v ----
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "fcp_defines.vh"
// Overview of operation
// [R1] Four channels, one output line each
// [R2] Generator offers thirteen clocks from master
// [R3] Modulo counter gives divide by 1..1024
// [R4] Two linear dividers, 1 to 255
// [R5] Divider source picked by mode field
// [R6] Fields reset zero; zero divisor stops clock
// [R7] Divided clocks off at reset, clock stop
// [R8] Per-channel clock select, reset zero
// [R9] Sixteen-bit channel counter on selected clock
// [R10] Comparator makes events and output level
// [R11] Left period is period times prescale
// [R12] Period and duty double-buffered
// [R13] Channels start together on one write
// [R14] Clock stop freezes state, resumes later
// [R15] Configuration writes work with clock stopped
// [R16] Software access through mapped registers
// [R17] Interrupt controller must be level sensitive
// [R18] Center mode counts up then down
// [R19] Left mode counts up then wraps
// [R20] Update value applied at period end
// [R21] Period end flag, cleared by status read
module fcp_top #(
  parameter NCH = 4,
  parameter CW  = 16
) (
  input  wire           i_clk,
  input  wire           i_rst_b,
  input  wire           i_clk_on,   // Master clock enabled by power manager
  input  wire [11:0]    i_addr,     // Byte address
  input  wire [31:0]    i_wdata,    // Write data
  input  wire           i_wr,       // Write strobe
  input  wire           i_rd,       // Read strobe
  output reg  [31:0]    o_rdata,    // Read data, cycle after read
  output wire [NCH-1:0] o_wave,     // channel_wave_out lines
  output wire           o_irq       // Level interrupt
);
  //----------------------------------------
  // Clock-on synchroniser
  //----------------------------------------
  reg on_s1_r;  // First stage
  reg on_r;     // Second stage
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_s1_r <= 1'b0;
      on_r    <= 1'b0;
    end else begin
      on_s1_r <= i_clk_on;
      on_r    <= on_s1_r;
    end
  end
  //----------------------------------------
  // Registers
  //----------------------------------------
  reg [31:0]      mode_r;  // generator_mode_register
  reg [NCH-1:0]   ena_r;   // Channel enables
  reg [NCH-1:0]   imr_r;   // Interrupt mask
  reg [NCH-1:0]   isr_r;   // Period end flags
  reg [10:0]      cmr_r [0:NCH-1]; // channel_mode_register
  wire [3:0] a_src = mode_r[`FCP_MR_DIVIDER_A_SOURCE_SEL_LSB +: 4];
  wire [3:0] b_src = mode_r[`FCP_MR_DIVIDER_B_SOURCE_SEL_LSB +: 4];
  wire [7:0] a_div = mode_r[`FCP_MR_DIVIDER_A_FACTOR_LSB +: 8];
  wire [7:0] b_div = mode_r[`FCP_MR_DIVIDER_B_FACTOR_LSB +: 8];
  // Decode
  wire       in_ch   = (i_addr[11:9] == 3'h1) &&
                       (i_addr[8:7] == 2'b00);
  wire [1:0] ch_idx  = i_addr[6:5];
  wire [2:0] ch_reg  = i_addr[4:2];
  wire       w_mode  = i_wr && (i_addr == `FCP_OFS_MODE);
  wire       w_ena   = i_wr && (i_addr == `FCP_OFS_ENA);
  wire       w_dis   = i_wr && (i_addr == `FCP_OFS_DIS);
  wire       w_ier   = i_wr && (i_addr == `FCP_OFS_IER);
  wire       w_idr   = i_wr && (i_addr == `FCP_OFS_IDR);
  wire       r_isr   = i_rd && (i_addr == `FCP_OFS_ISR);
  //----------------------------------------
  // Modulo-n prescaler
  //----------------------------------------
  reg  [9:0]  pre_r;    // Free divider count
  wire [10:0] pre_tick; // Tick per power of two
  // [R14] counting frozen while clock stopped
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pre_r <= 10'h000;
    else if (on_r) pre_r <= pre_r + 10'h001;
  end
  // [R3] tick of divide 2^k when low k bits all ones
  // [R7] divided ticks need the clock on
  genvar k;
  assign pre_tick[0] = on_r;
  generate
    for (k = 1; k < 11; k = k + 1) begin : g_pre
      assign pre_tick[k] = on_r & (&pre_r[k-1:0]);
    end
  endgenerate
  //----------------------------------------
  // Linear dividers A and B
  //----------------------------------------
  reg [7:0] a_cnt_r;  // Divider A count
  reg [7:0] b_cnt_r;  // Divider B count
  // [R5] source from modulo counter
  wire a_in = (a_src < 4'hB) ? pre_tick[a_src] : 1'b0;
  wire b_in = (b_src < 4'hB) ? pre_tick[b_src] : 1'b0;
  // [R4] divide by factor; [R6] zero stops
  wire a_tick = a_in && (a_div != 8'h00) && (a_cnt_r >= a_div - 8'h01);
  wire b_tick = b_in && (b_div != 8'h00) && (b_cnt_r >= b_div - 8'h01);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_cnt_r <= 8'h00;
      b_cnt_r <= 8'h00;
    end else begin
      if (a_tick) a_cnt_r <= 8'h00;
      else if (a_in) a_cnt_r <= a_cnt_r + 8'h01;
      if (b_tick) b_cnt_r <= 8'h00;
      else if (b_in) b_cnt_r <= b_cnt_r + 8'h01;
    end
  end
  // [R2] thirteen selectable ticks
  wire [12:0] gen_tick = {b_tick, a_tick, pre_tick};
  //----------------------------------------
  // Channels
  //----------------------------------------
  wire [CW-1:0]  prd   [0:NCH-1];
  wire [CW-1:0]  dty   [0:NCH-1];
  wire [CW-1:0]  cnt   [0:NCH-1];
  wire [NCH-1:0] eop;
  genvar c;
  generate
    // [R1] one instance per channel
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire sel_me = i_wr && in_ch && (ch_idx == c);
      // [R8] channel clock select
      wire [3:0] csel = cmr_r[c][3:0];
      wire       tk   = (csel < 4'hD) ? gen_tick[csel] : 1'b0;
      fcp_chan #(.CW(CW)) u_ch (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_tick   (tk),
        .i_en     (ena_r[c]),
        .i_start  (w_ena & i_wdata[c] & ~ena_r[c]),
        .i_calg   (cmr_r[c][`FCP_CMR_CALG_BIT]),
        .i_cpol   (cmr_r[c][`FCP_CMR_CPOL_BIT]),
        .i_cpd    (cmr_r[c][`FCP_CMR_CPD_BIT]),
        .i_wr_prd (sel_me && (ch_reg == `FCP_OFS_CHANNEL_PERIOD_VALUE)),
        .i_wr_dty (sel_me && (ch_reg == `FCP_OFS_CHANNEL_DUTY_VALUE)),
        .i_wr_upd (sel_me && (ch_reg == `FCP_OFS_CUPD)),
        .i_wdata  (i_wdata[CW-1:0]),
        .o_prd    (prd[c]),
        .o_dty    (dty[c]),
        .o_cnt    (cnt[c]),
        .o_wave   (o_wave[c]),
        .o_eop    (eop[c])
      );
    end
  endgenerate
  //----------------------------------------
  // Register writes
  //----------------------------------------
  // [R15] writes accepted with clock stopped
  integer i;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // [R6] mode fields zero
      mode_r <= `FCP_RST_ZERO;
      ena_r  <= {NCH{1'b0}};
      imr_r  <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) cmr_r[i] <= 11'h000;
    end else begin
      // [R4] full 8-bit divisor fields kept
      if (w_mode) mode_r <= i_wdata & 32'h0FFF_0FFF;
      // [R13] enable several at once
      if (w_ena) ena_r <= ena_r | i_wdata[NCH-1:0];
      if (w_dis) ena_r <= ena_r & ~i_wdata[NCH-1:0];
      if (w_ier) imr_r <= imr_r | i_wdata[NCH-1:0];
      if (w_idr) imr_r <= imr_r & ~i_wdata[NCH-1:0];
      for (i = 0; i < NCH; i = i + 1) begin
        // Polarity and alignment only while stopped
        if (i_wr && in_ch && ch_idx == i && ch_reg == `FCP_OFS_CMR
            && !ena_r[i])
          cmr_r[i] <= i_wdata[10:0];
      end
    end
  end
  //----------------------------------------
  // Period end flags
  //----------------------------------------
  // [R21] set wins over read clear
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) isr_r <= {NCH{1'b0}};
    else isr_r <= (r_isr ? {NCH{1'b0}} : isr_r) | eop;
  end
  // [R17] level output for level-sensitive controller
  assign o_irq = |(isr_r & imr_r);
  //----------------------------------------
  // Read path
  //----------------------------------------
  // [R16] mapped register reads
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= 32'h0000_0000;
      if (i_addr == `FCP_OFS_MODE) o_rdata <= mode_r;
      else if (i_addr == `FCP_OFS_SR)
        o_rdata[NCH-1:0] <= ena_r;
      else if (i_addr == `FCP_OFS_IMR)
        o_rdata[NCH-1:0] <= imr_r;
      else if (i_addr == `FCP_OFS_ISR)
        o_rdata[NCH-1:0] <= isr_r;
      else if (in_ch) begin
        case (ch_reg)
          `FCP_OFS_CMR:  o_rdata[10:0]   <= cmr_r[ch_idx];
          `FCP_OFS_CHANNEL_DUTY_VALUE: o_rdata[CW-1:0] <= dty[ch_idx];
          `FCP_OFS_CHANNEL_PERIOD_VALUE: o_rdata[CW-1:0] <= prd[ch_idx];
          `FCP_OFS_CCNT: o_rdata[CW-1:0] <= cnt[ch_idx];
          default:       o_rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
  // [R11] period = prd x prescale via tick rate
endmodule

// ---- bench/fcp_chk.sv ----
`timescale 1ns/100ps
// Bus and pin checker for the controller
module fcp_chk #(
  parameter NCH = 4,
  parameter CW  = 16
) (
  input wire           i_clk,
  input wire           i_rst_b,
  input wire           i_clk_on,
  input wire [11:0]    i_addr,
  input wire [31:0]    i_wdata,
  input wire           i_wr,
  input wire           i_rd,
  input wire [31:0]    o_rdata,
  input wire [NCH-1:0] o_wave,
  input wire           o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside answer");
  chk_unmapped_zero: assert property
    (i_rd && i_addr == 12'h100 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_stop_freeze: assert property
    ((!i_clk_on && !i_wr)[*5] |-> $stable(o_wave))
    else $error("waves moved with clock stopped");
  chk_cnt_width: assert property
    (i_rd && i_addr == 12'h20C |=> o_rdata[31:16] == 16'h0)
    else $error("counter wider than sixteen bits");
  chk_ena_status: assert property
    (i_wr && i_addr == 12'h004 ##1 !i_wr ##1 i_rd && i_addr == 12'h00C
     |=> (o_rdata[3:0] & $past(i_wdata[3:0], 3)) == $past(i_wdata[3:0], 3))
    else $error("enabled channel not in status");
  chk_dis_status: assert property
    (i_wr && i_addr == 12'h008 ##1 !i_wr ##1 i_rd && i_addr == 12'h00C
     |=> (o_rdata[3:0] & $past(i_wdata[3:0], 3)) == 4'h0)
    else $error("disabled channel still in status");
  chk_mode_back: assert property
    (i_wr && i_addr == 12'h000 ##1 !i_wr ##1 i_rd && i_addr == 12'h000
     |=> o_rdata == ($past(i_wdata, 3) & 32'h0FFF_0FFF))
    else $error("mode register read back wrong");
  chk_irq_hold: assert property (o_irq && !i_rd && !i_wr |=> o_irq)
    else $error("interrupt dropped without status read");
  cov_irq: cover property ($rose(o_irq));
  cov_wave: cover property ($rose(o_wave[0]));
  cov_stop: cover property ($fell(i_clk_on));
endmodule
bind fcp_top fcp_chk #(.NCH(NCH), .CW(CW)) u_fcp_chk (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_clk_on(i_clk_on), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_wave(o_wave), .o_irq(o_irq));

// ---- bench/fcp_load.sv ----
`timescale 1ns/100ps
// Loads on the wave pins; times every pulse
module fcp_load (
  input  wire logic             i_clk,
  input  wire logic [3:0]       i_wave,
  output logic      [3:0][15:0] o_per,
  output logic      [3:0][15:0] o_hi
);
  logic [3:0][15:0] cnt = '0;  // Cycles since last rise
  logic [3:0]       prev = '0; // Level one cycle ago
  // Rise closes a period, fall closes the high phase
  always @(posedge i_clk) begin
    prev <= i_wave;
    for (int c = 0; c < 4; c++) begin
      cnt[c] <= cnt[c] + 16'h1;
      if (i_wave[c] && !prev[c]) begin
        o_per[c] <= cnt[c];
        cnt[c]   <= 16'h1;
      end
      if (!i_wave[c] && prev[c]) o_hi[c] <= cnt[c];
    end
  end
endmodule

// ---- bench/fcp_top_tb.sv ----
`timescale 1ns/100ps
module fcp_top_tb;
  logic             i_clk = 1'b0;
  logic             i_rst_b = 1'b0;  // Reset, active low
  logic             i_clk_on = 1'b1; // Power manager clock enable
  logic [11:0]      i_addr = 12'h000;
  logic [31:0]      i_wdata = 32'h0;
  logic             i_wr = 1'b0;
  logic             i_rd = 1'b0;
  logic [31:0]      o_rdata;
  logic [3:0]       o_wave;
  logic             o_irq;
  logic [3:0][15:0] per, hi;         // Pulse timing from the loads
  integer           seed = 32'he628;
  integer           err_total = 0;
  integer           n_compared = 0;
  logic [31:0]      d, v, a;
  logic [11:0] rst_a [7] = '{12'h000, 12'h00C, 12'h018, 12'h01C,
                             12'h200, 12'h260, 12'h100};
  logic [11:0] cfg_a [11] = '{12'h000, 12'h200, 12'h208, 12'h204,
    12'h220, 12'h228, 12'h224, 12'h240, 12'h248, 12'h244, 12'h010};
  logic [31:0] cfg_d [11] = '{32'h103, 32'h1, 32'h5, 32'h2, 32'h100,
    32'h4, 32'h1, 32'hB, 32'h3, 32'h1, 32'h1};
  always #4 i_clk = ~i_clk;
  fcp_top u_fcp_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_clk_on(i_clk_on), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wave(o_wave),
    .o_irq(o_irq));
  fcp_load u_fcp_load (.i_clk(i_clk), .i_wave(o_wave), .o_per(per),
    .o_hi(hi));
  // One-cycle write strobe
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    @(posedge i_clk);
    i_addr  <= ad;
    i_wdata <= dt;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read; data taken in the answer cycle
  task automatic rd(input logic [11:0] ad, output logic [31:0] dt);
    @(posedge i_clk);
    i_addr <= ad;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    dt = o_rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 200 && o_irq !== 1'b1; k++) @(posedge i_clk);
  endtask
  task automatic conclude;
    $display("mismatches %0d, compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    foreach (rst_a[k]) begin
      rd(rst_a[k], v);
      chk("reset value", 32'h0, v);
    end
    // Random configuration with the clock stopped
    i_clk_on <= 1'b0;
    repeat (4) begin
      d = $random(seed);
      wr(12'h000, d);
      rd(12'h000, v);
      chk("mode", d & 32'h0FFF_0FFF, v);
      wr(12'h264, d);
      rd(12'h264, v);
      chk("duty3", {16'h0, d[15:0]}, v);
    end
    i_clk_on <= 1'b1;
    foreach (cfg_a[k]) wr(cfg_a[k], cfg_d[k]);
    wr(12'h004, 32'h7);
    rd(12'h00C, v);
    chk("status", 32'h7, v);
    repeat (100) @(posedge i_clk);
    chk("per0", 32'h0A, {16'h0, per[0]});
    chk("hi0", 32'h04, {16'h0, hi[0]});
    chk("per1", 32'h08, {16'h0, per[1]});
    chk("per2", 32'h12, {16'h0, per[2]});
    rd(12'h01C, v);
    wait_irq;
    chk("irq", 32'h1, {31'h0, o_irq});
    rd(12'h01C, v);
    chk("isr", 32'h1, {31'h0, v[0]});
    chk("irq clr", 32'h0, {31'h0, o_irq});
    wr(12'h210, 32'h1);
    repeat (60) @(posedge i_clk);
    chk("hi0 upd", 32'h02, {16'h0, hi[0]});
    chk("per0 upd", 32'h0A, {16'h0, per[0]});
    rd(12'h204, v);
    chk("duty0", 32'h1, v);
    i_clk_on <= 1'b0;
    repeat (5) @(posedge i_clk);
    rd(12'h20C, a);
    repeat (30) @(posedge i_clk);
    rd(12'h20C, v);
    chk("frozen cnt", a, v);
    i_clk_on <= 1'b1;
    repeat (60) @(posedge i_clk);
    chk("per0 resume", 32'h0A, {16'h0, per[0]});
    wr(12'h008, 32'hF);
    rd(12'h00C, v);
    chk("status off", 32'h0, v);
    conclude;
  end
endmodule
